// ===== logic/ppm_pkg.sv
// Port mux package: register map, reset values, fields and pin carriers.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package ppm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_P0_DIR = 8'h00;
  localparam logic [7:0] OFS_P0_PU = 8'h04;
  localparam logic [7:0] OFS_P0_LATCH = 8'h08;
  localparam logic [7:0] OFS_P0_PIN = 8'h0c;
  localparam logic [7:0] OFS_P0_CTRL = 8'h10;
  localparam logic [7:0] OFS_P1_DIR = 8'h14;
  localparam logic [7:0] OFS_P1_PU = 8'h18;
  localparam logic [7:0] OFS_P1_LATCH = 8'h1c;
  localparam logic [7:0] OFS_P1_PIN = 8'h20;
  localparam logic [7:0] OFS_P1_CTRL = 8'h24;
  localparam logic [7:0] OFS_P1_ANALOG = 8'h28;
  localparam logic [7:0] OFS_P2_ANALOG = 8'h2c;
  localparam logic [7:0] OFS_ALT_SW = 8'h30;
  localparam logic [7:0] OFS_P4_FUNC = 8'h34;
  localparam logic [7:0] OFS_EDGE = 8'h38;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h3c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h40;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_P0_DIR = 3'h7;
  localparam logic [7:0] RST_P1_DIR = 8'hff;
  localparam logic [2:0] RST_P1_ANALOG = 3'h0;
  localparam logic [7:0] RST_P2_ANALOG = 8'hff;
  localparam logic [5:0] RST_EDGE = 6'h15;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned NUM_IRQ = 3;
  localparam int unsigned IRQ_A = 0;
  localparam int unsigned IRQ_F = 1;
  localparam int unsigned IRQ_H = 2;
  localparam int unsigned P4F_RTC_EN = 0;
  localparam int unsigned P4F_RTC_RAW = 1;
  localparam int unsigned P4F_HZ_EN = 2;
  localparam int unsigned P4F_TRIM_EN = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
  } ppm_pad_s;

  typedef struct packed {
    logic drive;
    logic out;
    logic oe;
  } ppm_fn_s;

  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_RESP = 2'b10
  } ppm_wstate_e;

endpackage : ppm_pkg

// ===== logic/ppm_pin_cell.sv
// One digital pin: port latch or peripheral drive, direction, pull-up and
// analog disconnect. Purely combinational; the caller registers the pad.
// Assumes dir_in is 1 for input.
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_cell
  import ppm_pkg::*;
(
  input wire logic dir_in,
  input wire logic pu,
  input wire logic latch,
  input wire logic ctrl,
  input wire logic analog,
  input wire ppm_fn_s fn,
  input wire logic pin_in,
  output ppm_pad_s pad,
  output logic din
);

  always_comb
  begin
    pad.out = latch;
    pad.oe = ~dir_in;
    if (ctrl && fn.drive)
    begin
      pad.out = fn.out;
      pad.oe = fn.oe;
    end
    // Analog pins must not fight the converter, so the buffer is released
    if (analog)
    begin
      pad.oe = 1'b0;
    end
    pad.pull_up = pu & ~pad.oe & ~analog;
    din = pin_in & ~analog;
  end

endmodule : ppm_pin_cell
`default_nettype wire

// ===== logic/ppm_edge_det.sv
// Valid-edge detector for one external interrupt input.
// Assumes the level is already synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module ppm_edge_det
  import ppm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic level,
  input wire logic rise_en,
  input wire logic fall_en,
  output logic event_pulse
);

  logic prev;

  // Follows the pin through reset too, so release shows no false edge
  always_ff @(posedge aclk)
  begin
    prev <= level;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_pulse <= 1'b0;
    end
    else
    begin
      event_pulse <= (rise_en & level & ~prev) | (fall_en & ~level & prev);
    end
  end

endmodule : ppm_edge_det
`default_nettype wire

// ===== logic/ppm_port_mux.sv
// Port 0/1 control and shared-pin routing, with the relocatable serial B pins.
// Assumes pins are sampled synchronously to aclk and peripherals sit on aclk.
//
// Functional notes
// - Port-0 pins: per-bit input/output direction
// - Port-0 pins: per-bit pull-up enable
// - Port-1 pins: per-bit input/output direction
// - Port-1 pins: per-bit pull-up enable
// - P10-P12 come up digital inputs
// - Interrupt inputs: rising, falling or both
// - Alt switch moves serial B pins
// - P00 feeds timer16 count and capture
// - P01 capture-B input or timer16 output
// - P42 outputs trimming clock
// - P40 RTC clock, P41 one-hertz clock while the alt switch is off
// - Serial A on P10, P11, P12
// - Async transmit P13, receive P14
// - H timers on P15/P16; P16 interrupt
// - P17 timer8a count in or output
// - Port-2 analog pins reset analog
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux
  import ppm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] p0_in,
  output ppm_pad_s [2:0] p0_pad,
  input wire logic [7:0] p1_in,
  output ppm_pad_s [7:0] p1_pad,
  input wire logic [2:0] p4_in,
  output ppm_pad_s [2:0] p4_pad,
  input wire logic [2:0] p6_in,
  output ppm_pad_s [2:0] p6_pad,
  input wire logic p120_in,
  output ppm_pad_s p120_pad,
  input wire logic timer16_out,
  output logic timer16_count_capture_in,
  output logic timer16_capture_b_in,
  input wire logic timer8a_out,
  output logic timer8a_count_in,
  input wire logic htimer_a_out,
  input wire logic htimer_b_out,
  input wire ppm_fn_s sync_serial_a_clk_fn,
  output logic sync_serial_a_clk_in,
  output logic sync_serial_a_din,
  input wire logic sync_serial_a_dout,
  input wire ppm_fn_s sync_serial_b_clk_fn,
  output logic sync_serial_b_clk_in,
  output logic sync_serial_b_din,
  input wire ppm_fn_s sync_serial_b_dout_fn,
  output logic sync_serial_b_select,
  input wire logic async_tx_out,
  output logic async_rx_in,
  input wire logic rtc_divided_clk_out,
  input wire logic rtc_raw_osc_out,
  input wire logic rtc_second_clk_out,
  input wire logic trim_clock_out,
  output logic [2:0] analog_in_sel,
  output logic [7:0] port2_analog_mode,
  output logic [2:0] ext_irq_event,
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0] port0_direction_reg;
  logic [2:0] port0_pullup_reg;
  logic [2:0] port0_latch;
  logic [2:0] port0_ctrl;
  logic [7:0] port1_direction_reg;
  logic [7:0] port1_pullup_reg;
  logic [7:0] port1_latch;
  logic [7:0] port1_ctrl;
  logic alt_switch_ctrl;
  logic [3:0] port4_func;
  logic [5:0] edge_sel;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] p0_din;
  logic [7:0] p1_din;
  logic [2:0] irq_level;
  logic [2:0] irq_pulse;
  ppm_pad_s [2:0] next_p0_pad;
  ppm_pad_s [7:0] next_p1_pad;
  ppm_fn_s [2:0] p0_fn;
  ppm_fn_s [7:0] p1_fn;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:2] <= OFS_IRQ_MASK[7:2]);
  endfunction : mapped

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  ppm_wstate_e wstate;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;

  assign s_axi_awready = (wstate == WS_IDLE) && !aw_hold;
  assign s_axi_wready = (wstate == WS_IDLE) && !w_hold;
  assign s_axi_bvalid = (wstate == WS_RESP);
  assign wr_fire = (wstate == WS_IDLE) && aw_hold && w_hold;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      else if (wr_fire)
      begin
        w_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wstate <= WS_IDLE;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      unique case (wstate)
        WS_IDLE:
        begin
          if (wr_fire)
          begin
            wstate <= WS_RESP;
            s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WS_RESP:
        begin
          if (s_axi_bready)
          begin
            wstate <= WS_IDLE;
          end
        end
        default:
        begin
          wstate <= WS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic wr_en;

  assign wr_en = wr_fire && w_lane0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port0_direction_reg <= RST_P0_DIR;
      port0_pullup_reg <= 3'h0;
      port1_direction_reg <= RST_P1_DIR;
      port1_pullup_reg <= 8'h00;
      port0_latch <= 3'h0;
      port0_ctrl <= 3'h0;
      port1_latch <= 8'h00;
      port1_ctrl <= 8'h00;
      analog_in_sel <= RST_P1_ANALOG;
      port2_analog_mode <= RST_P2_ANALOG;
      alt_switch_ctrl <= 1'b0;
      port4_func <= 4'h0;
      edge_sel <= RST_EDGE;
      irq_mask <= 3'h0;
    end
    else if (wr_en)
    begin
      if (hit(aw_addr, OFS_P0_DIR)) port0_direction_reg <= w_byte[2:0];
      if (hit(aw_addr, OFS_P0_PU)) port0_pullup_reg <= w_byte[2:0];
      if (hit(aw_addr, OFS_P1_DIR)) port1_direction_reg <= w_byte;
      if (hit(aw_addr, OFS_P1_PU)) port1_pullup_reg <= w_byte;
      if (hit(aw_addr, OFS_P0_LATCH)) port0_latch <= w_byte[2:0];
      if (hit(aw_addr, OFS_P0_CTRL)) port0_ctrl <= w_byte[2:0];
      if (hit(aw_addr, OFS_P1_LATCH)) port1_latch <= w_byte;
      if (hit(aw_addr, OFS_P1_CTRL)) port1_ctrl <= w_byte;
      if (hit(aw_addr, OFS_P1_ANALOG)) analog_in_sel <= w_byte[2:0];
      if (hit(aw_addr, OFS_P2_ANALOG)) port2_analog_mode <= w_byte;
      if (hit(aw_addr, OFS_ALT_SW)) alt_switch_ctrl <= w_byte[0];
      if (hit(aw_addr, OFS_P4_FUNC)) port4_func <= w_byte[3:0];
      if (hit(aw_addr, OFS_EDGE)) edge_sel <= w_byte[5:0];
      if (hit(aw_addr, OFS_IRQ_MASK)) irq_mask <= w_byte[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [2:0] irq_clr;

  assign irq_clr = (wr_en && hit(aw_addr, OFS_IRQ_STAT)) ? w_byte[2:0] : 3'h0;

  // An edge in the clearing cycle is kept: set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_pulse;
      irq <= |(((irq_stat & ~irq_clr) | irq_pulse) & irq_mask);
    end
  end

  assign ext_irq_event = irq_pulse;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb
  begin
    rd_byte = 8'h00;
    if (hit(s_axi_araddr, OFS_P0_DIR)) rd_byte = {5'h00, port0_direction_reg};
    if (hit(s_axi_araddr, OFS_P0_PU)) rd_byte = {5'h00, port0_pullup_reg};
    if (hit(s_axi_araddr, OFS_P0_LATCH)) rd_byte = {5'h00, port0_latch};
    if (hit(s_axi_araddr, OFS_P0_PIN)) rd_byte = {5'h00, p0_din};
    if (hit(s_axi_araddr, OFS_P0_CTRL)) rd_byte = {5'h00, port0_ctrl};
    if (hit(s_axi_araddr, OFS_P1_DIR)) rd_byte = port1_direction_reg;
    if (hit(s_axi_araddr, OFS_P1_PU)) rd_byte = port1_pullup_reg;
    if (hit(s_axi_araddr, OFS_P1_LATCH)) rd_byte = port1_latch;
    if (hit(s_axi_araddr, OFS_P1_PIN)) rd_byte = p1_din;
    if (hit(s_axi_araddr, OFS_P1_CTRL)) rd_byte = port1_ctrl;
    if (hit(s_axi_araddr, OFS_P1_ANALOG)) rd_byte = {5'h00, analog_in_sel};
    if (hit(s_axi_araddr, OFS_P2_ANALOG)) rd_byte = port2_analog_mode;
    if (hit(s_axi_araddr, OFS_ALT_SW)) rd_byte = {7'h00, alt_switch_ctrl};
    if (hit(s_axi_araddr, OFS_P4_FUNC)) rd_byte = {4'h0, port4_func};
    if (hit(s_axi_araddr, OFS_EDGE)) rd_byte = {2'h0, edge_sel};
    if (hit(s_axi_araddr, OFS_IRQ_STAT)) rd_byte = {5'h00, irq_stat};
    if (hit(s_axi_araddr, OFS_IRQ_MASK)) rd_byte = {5'h00, irq_mask};
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral drive requests for ports 0 and 1
  // ----------------------------------------------------------------
  always_comb
  begin
    p0_fn = '0;
    p1_fn = '0;
    // output only while P01 is an output
    p0_fn[1] = '{drive: ~port0_direction_reg[1], out: timer16_out, oe: 1'b1};
    p1_fn[0] = sync_serial_a_clk_fn;
    p1_fn[2] = '{drive: 1'b1, out: sync_serial_a_dout, oe: 1'b1};
    p1_fn[3] = '{drive: 1'b1, out: async_tx_out, oe: 1'b1};
    p1_fn[5] = '{drive: 1'b1, out: htimer_a_out, oe: 1'b1};
    p1_fn[6] = '{drive: ~port1_direction_reg[6], out: htimer_b_out, oe: 1'b1};
    // output only while P17 is an output
    p1_fn[7] = '{drive: ~port1_direction_reg[7], out: timer8a_out, oe: 1'b1};
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_p0
      ppm_pin_cell u_cell (
        .dir_in(port0_direction_reg[gi]),
        .pu(port0_pullup_reg[gi]),
        .latch(port0_latch[gi]),
        .ctrl(port0_ctrl[gi]),
        .analog(1'b0),
        .fn(p0_fn[gi]),
        .pin_in(p0_in[gi]),
        .pad(next_p0_pad[gi]),
        .din(p0_din[gi])
      );
    end
    for (gi = 0; gi < 8; gi++)
    begin : g_p1
      ppm_pin_cell u_cell (
        .dir_in(port1_direction_reg[gi]),
        .pu(port1_pullup_reg[gi]),
        .latch(port1_latch[gi]),
        .ctrl(port1_ctrl[gi]),
        .analog((gi < 3) && analog_in_sel[gi % 3]),
        .fn(p1_fn[gi]),
        .pin_in(p1_in[gi]),
        .pad(next_p1_pad[gi]),
        .din(p1_din[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered pads and peripheral inputs
  // ----------------------------------------------------------------
  // One cycle of latency on every pad keeps glitches off the board
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      p0_pad <= '0;
      p1_pad <= '0;
    end
    else
    begin
      p0_pad <= next_p0_pad;
      p1_pad <= next_p1_pad;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer16_count_capture_in <= 1'b0;
      timer16_capture_b_in <= 1'b0;
      timer8a_count_in <= 1'b0;
      sync_serial_a_clk_in <= 1'b0;
      sync_serial_a_din <= 1'b0;
      async_rx_in <= 1'b0;
    end
    else
    begin
      timer16_count_capture_in <= port0_ctrl[0] & p0_din[0];
      // capture-B input while P01 is input
      timer16_capture_b_in <= port0_ctrl[1] & port0_direction_reg[1] & p0_din[1];
      // count input while P17 is input
      timer8a_count_in <= port1_ctrl[7] & port1_direction_reg[7] & p1_din[7];
      // serial A clock and data in
      sync_serial_a_clk_in <= port1_ctrl[0] & p1_din[0];
      sync_serial_a_din <= port1_ctrl[1] & p1_din[1];
      async_rx_in <= port1_ctrl[4] & p1_din[4];
    end
  end

  // ----------------------------------------------------------------
  // Ports 4, 6, 12: relocatable serial B and clock outputs
  // ----------------------------------------------------------------
  ppm_pad_s sb_clk_pad;
  ppm_pad_s sb_dout_pad;

  assign sb_clk_pad = {sync_serial_b_clk_fn.out,
                       sync_serial_b_clk_fn.drive & sync_serial_b_clk_fn.oe, 1'b0};
  assign sb_dout_pad = {sync_serial_b_dout_fn.out,
                        sync_serial_b_dout_fn.drive & sync_serial_b_dout_fn.oe, 1'b0};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      p4_pad <= '0;
      p6_pad <= '0;
      p120_pad <= '0;
      sync_serial_b_clk_in <= 1'b0;
      sync_serial_b_din <= 1'b0;
      sync_serial_b_select <= 1'b0;
    end
    else
    begin
      p4_pad <= '0;
      p6_pad <= '0;
      p120_pad <= '0;
      // alt switch picks serial B pins
      if (alt_switch_ctrl)
      begin
        p4_pad[0] <= sb_clk_pad;
        p120_pad <= sb_dout_pad;
        sync_serial_b_clk_in <= p4_in[0];
        sync_serial_b_din <= p4_in[1];
      end
      else
      begin
        p6_pad[0] <= sb_clk_pad;
        p6_pad[2] <= sb_dout_pad;
        sync_serial_b_clk_in <= p6_in[0];
        sync_serial_b_din <= p6_in[1];
        // RTC clocks only while P40/P41 are free
        p4_pad[0] <= '{out: port4_func[P4F_RTC_RAW] ? rtc_raw_osc_out : rtc_divided_clk_out,
                       oe: port4_func[P4F_RTC_EN],
                       pull_up: 1'b0};
        p4_pad[1] <= '{out: rtc_second_clk_out, oe: port4_func[P4F_HZ_EN], pull_up: 1'b0};
      end
      p4_pad[2] <= '{out: trim_clock_out, oe: port4_func[P4F_TRIM_EN], pull_up: 1'b0};
      // Chip select shares P42, so it reads low while the clock is driven
      sync_serial_b_select <= p4_in[2] & ~port4_func[P4F_TRIM_EN];
    end
  end

  // ----------------------------------------------------------------
  // External interrupt edge detection
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_level[IRQ_A] = p120_in;
    irq_level[IRQ_F] = port1_ctrl[6] & p1_din[6];
    irq_level[IRQ_H] = port0_ctrl[2] & p0_din[2];
  end

  generate
    for (gi = 0; gi < NUM_IRQ; gi++)
    begin : g_irq
      ppm_edge_det u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(irq_level[gi]),
        .rise_en(edge_sel[2 * gi]),
        .fall_en(edge_sel[2 * gi + 1]),
        .event_pulse(irq_pulse[gi])
      );
    end
  endgenerate

endmodule : ppm_port_mux
`default_nettype wire

// ===== sim/ppm_port_mux_props.sv
// Checker for the port mux: bus handshakes, reset state, pads and edge events.
// Sees only the mux ports; bound onto every mux instance below.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux_props
  import ppm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0] p1_in,
  input wire ppm_pad_s [7:0] p1_pad,
  input wire logic [7:0] port2_analog_mode,
  input wire logic [2:0] ext_irq_event,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst; $rose(aresetn) |-> p1_pad == '0; endproperty
  a_rst: assert property (p_rst) else $error("pads not idle after reset");
  property p_ana; $rose(aresetn) |-> port2_analog_mode == 8'hff; endproperty
  a_ana: assert property (p_ana) else $error("port 2 not analog after reset");
  property p_pu; p1_pad[7].oe |-> !p1_pad[7].pull_up; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on a driven pin");
  property p_ev; ext_irq_event[1] |-> $past(p1_in[6]) != $past(p1_in[6], 2); endproperty
  a_ev: assert property (p_ev) else $error("event without an edge");
  property p_rd; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd: assert property (p_rd) else $error("read data not held");
  property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar: assert property (p_ar) else $error("read taken while busy");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_rv; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read response late");
  c_irq: cover property ($rose(irq));
  c_ev: cover property (ext_irq_event[1]);
  c_hold: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : ppm_port_mux_props
bind ppm_port_mux ppm_port_mux_props i_ppm_port_mux_props (.*);
`default_nettype wire

// ===== sim/ppm_board.sv
// Board circuitry on one port: external drivers, pull-ups, open pins.
// Assumes pads come straight from the mux.
`timescale 1ns/1ps
`default_nettype none
module ppm_board
  import ppm_pkg::*;
#(parameter int N = 8)
(
  input wire logic aclk,
  input wire ppm_pad_s [N-1:0] pad,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  output logic [N-1:0] lvl
);
  logic [N-1:0] flt = '0;
  // Open pins wander so a missing pull-up never reads as a lucky level
  always @(posedge aclk) flt <= ~flt;
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      lvl[i] = pad[i].oe ? pad[i].out : ext_en[i] ? ext_val[i] : pad[i].pull_up | flt[i];
    end
  end
endmodule : ppm_board
`default_nettype wire

// ===== sim/test_ppm_port_mux.sv
// Bench for the port mux: bus tasks, board model on port 1.
// Assumes the checker binds itself onto the mux.
`timescale 1ns/1ps
`default_nettype none
module test_ppm_port_mux
  import ppm_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, p120_in;
  logic [7:0] s_axi_awaddr, s_axi_araddr, p1_in, port2_analog_mode, b1e, b1v;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] p0_in, p4_in, p6_in, analog_in_sel, ext_irq_event;
  logic timer16_out, timer8a_out, htimer_a_out, htimer_b_out, sync_serial_a_dout, async_tx_out;
  logic rtc_divided_clk_out, rtc_raw_osc_out, rtc_second_clk_out, trim_clock_out, async_rx_in;
  logic timer16_count_capture_in, timer16_capture_b_in, timer8a_count_in, sync_serial_a_clk_in;
  logic sync_serial_a_din, sync_serial_b_clk_in, sync_serial_b_din, sync_serial_b_select;
  ppm_fn_s sync_serial_a_clk_fn, sync_serial_b_clk_fn, sync_serial_b_dout_fn;
  ppm_pad_s [2:0] p0_pad, p4_pad, p6_pad;
  ppm_pad_s [7:0] p1_pad;
  ppm_pad_s p120_pad;
  int bad_count, tests_run;
  ppm_port_mux i_ppm_port_mux (.*);
  ppm_board i_ppm_board (.aclk(aclk), .pad(p1_pad), .ext_en(b1e), .ext_val(b1v), .lvl(p1_in));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : wr
  // Late rready exercises held read data
  task rc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    chk(n, s_axi_rdata, e);
    chk("resp", s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask : rc
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task t_reset;
    rc("p0dir", OFS_P0_DIR, 32'h7);
    rc("p1dir", OFS_P1_DIR, 32'hff);
    rc("p1pu", OFS_P1_PU, 32'h0);
    rc("p1an", OFS_P1_ANALOG, 32'h0);
    rc("p2an", OFS_P2_ANALOG, 32'hff);
    rc("nomap", 8'h44, 32'h0, RESP_SLVERR);
  endtask : t_reset
  task t_port;
    wr(OFS_P1_LATCH, 32'ha5);
    wr(OFS_P1_DIR, 32'h0f);
    wr(OFS_P1_PU, 32'hff);
    wr(OFS_P0_DIR, 32'h2);
    wr(OFS_P0_PU, 32'h2);
    repeat (3) @(posedge aclk);
    rc("p1pin", OFS_P1_PIN, 32'haf);
    chk("p0oe", {p0_pad[2].oe, p0_pad[1].oe, p0_pad[0].oe}, 3'b101);
    chk("p0pu", p0_pad[1].pull_up, 1'b1);
    chk("p1pad", {p1_pad[7].oe, p1_pad[7].pull_up, p1_pad[0].oe, p1_pad[0].pull_up}, 4'h9);
  endtask : t_port
  task t_periph;
    wr(OFS_P1_CTRL, 32'hff);
    wr(OFS_P1_DIR, 32'h50);
    wr(OFS_P0_CTRL, 32'h7);
    wr(OFS_P0_DIR, 32'h3);
    {async_tx_out, htimer_a_out, timer8a_out} <= 3'b100;
    {b1e[4], b1v[4]} <= 2'b11;
    p0_in <= 3'h3;
    repeat (3) @(posedge aclk);
    chk("txd", p1_pad[3].out, 1'b1);
    chk("rxd", async_rx_in, 1'b1);
    chk("htim", p1_pad[5].out, 1'b0);
    chk("t8out", p1_pad[7].out, 1'b0);
    chk("t16in", {timer16_count_capture_in, timer16_capture_b_in}, 2'b11);
  endtask : t_periph
  task t_edge;
    logic [3:0] nr, nf;
    b1e[6] <= 1'b1;
    for (int m = 1; m < 4; m++)
    begin
      wr(OFS_EDGE, m << 2);
      wr(OFS_IRQ_STAT, 32'h7);
      nr = 4'h0;
      nf = 4'h0;
      b1v[6] <= 1'b1;
      repeat (8) @(posedge aclk) nr += ext_irq_event[1];
      b1v[6] <= 1'b0;
      repeat (8) @(posedge aclk) nf += ext_irq_event[1];
      chk("rise", nr, m & 1);
      chk("fall", nf, m >> 1);
    end
    chk("masked", irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h2);
    repeat (3) @(posedge aclk);
    chk("irq", irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h2);
    repeat (3) @(posedge aclk);
    chk("clr", irq, 1'b0);
    rc("stat", OFS_IRQ_STAT, 32'h0);
  endtask : t_edge
  task t_alt;
    p4_in <= 3'h2;
    p6_in <= 3'h5;
    wr(OFS_ALT_SW, 32'h1);
    repeat (3) @(posedge aclk);
    chk("altdin", sync_serial_b_din, 1'b1);
    wr(OFS_ALT_SW, 32'h0);
    repeat (3) @(posedge aclk);
    chk("homedin", sync_serial_b_din, 1'b0);
  endtask : t_alt
  initial
  begin
    repeat (3000) @(posedge aclk);
    bad_count++;
    stop_test;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready, p0_in, b1e, b1v} = '0;
    {p4_in, p6_in, p120_in, timer16_out, timer8a_out, htimer_a_out, htimer_b_out} = '0;
    {sync_serial_a_dout, async_tx_out, rtc_divided_clk_out, rtc_raw_osc_out} = '0;
    {rtc_second_clk_out, trim_clock_out, sync_serial_a_clk_fn, sync_serial_b_clk_fn} = '0;
    {sync_serial_b_dout_fn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_port;
    t_periph;
    t_edge;
    t_alt;
    stop_test;
  end
endmodule : test_ppm_port_mux
`default_nettype wire
